// file: verilog/pkf_alias.sv
// packed-integer register file aliased onto the floating-point data slots
// Contract
// - soft fpu trap flag set: every packed op faults invalid opcode
// - trap clear, context switch flag set: packed op faults device unavailable
// - eight 64-bit packed registers share low bits of physical slots
// - packed-to-slot mapping is by physical index, ignores top of stack
// - floating-point slot write makes low 64 bits visible as packed register
// - packed write fills slot low 64 bits and sets bits 64-79 to ones
// - packed read-only op leaves all slot data unchanged
// - packed ops except clear set every tag to valid
// - clear op sets every tag empty and keeps register data
// - every packed op including clear sets top of stack to zero
// - packed ops keep other status bits, control word, pointers, opcode
// - packed data and execution never depend on the tag word
// - ordinary floating-point ops set modified slot tag to valid or empty
// - saves store computed tags, then all live tags become empty
// - restores keep empty tags, recompute others from slot contents
// - packed ops raise no numeric exception, change no arithmetic flags
// - pending fp error faults before packed op, state kept for handler
// - memory faults allowed; alignment fault only when checking enabled
// - extended save and restore also carry wide vector state
// - stack slot n is physical (top plus n) mod eight
//
// The register offsets and the APB slave port are this design's own decisions.
module pkf_alias
(
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic op_valid, // pipeline issues an operation
	input wire logic [3:0] op_code, // pkf_op_t code
	input wire logic [2:0] op_reg, // packed register or stack-relative index
	input wire logic [79:0] op_wdata, // write data (packed uses low 64)
	input wire logic [15:0] op_tags_in, // tag image from memory for restores
	input wire logic fp_exc_pending, // unmasked fp exception waiting
	input wire logic [1:0] mem_fault, // memory fault kind of this access
	input wire logic misaligned, // operand is misaligned
	input wire logic cpl3_ac, // privilege 3 with flags alignment bit set
	output logic [63:0] pk_rdata, // packed register read data
	output logic [79:0] st_rdata, // stack-relative slot read data
	output logic [15:0] tags_out, // computed tag image for saves
	output logic save_ext_vec, // save/restore includes wide vector state
	output logic done, // operation finished this cycle
	output logic [2:0] fault // pkf_fault_t of the operation
);
	logic [79:0] slot_r [8];
	logic [79:0] slot_nxt [8];
	logic [15:0] tagw_r, tagw_nxt;
	logic [15:0] fpsw_r, fpsw_nxt;
	logic [15:0] fpcw_r, fpcw_nxt;
	logic [15:0] stag_r, stag_nxt;
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [2:0] sel_r, sel_nxt;
	logic [2:0] fault_r, fault_nxt;
	logic [63:0] pk_rdata_r, pk_rdata_nxt;
	logic [79:0] st_rdata_r, st_rdata_nxt;
	logic [15:0] tags_out_r, tags_out_nxt;
	logic ext_r, ext_nxt;
	logic done_r, done_nxt;
	logic [31:0] rdata_nxt;
	logic apb_wr, apb_rd, packed_op, is_save, is_restore, fault_hit;
	logic [2:0] top_of_stack_field, st_phys;
	pkf_pkg::pkf_op_t op;
	pkf_pkg::pkf_fault_t flt;

	// classify a slot value as nonzero, zero or special
	function automatic logic [1:0] tag_of(input logic [79:0] v);
		logic [14:0] e;
		e = v[78:64];
		if (e == 15'h7FFF)
			tag_of = pkf_pkg::TAG_SPECIAL;
		else if (e == 15'h0000)
			tag_of = (v[63:0] == 64'h0) ? pkf_pkg::TAG_ZERO : pkf_pkg::TAG_SPECIAL;
		else
			tag_of = v[63] ? pkf_pkg::TAG_VALID : pkf_pkg::TAG_SPECIAL;
	endfunction : tag_of

	// mask of the tag fields marked empty in a tag image
	function automatic logic [15:0] empty_mask(input logic [15:0] t);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 8; i++)
		begin
			if (t[2*i +: 2] == pkf_pkg::TAG_EMPTY)
				m[2*i +: 2] = pkf_pkg::TAG_EMPTY;
		end
		empty_mask = m;
	endfunction : empty_mask

	// apb answers in the access cycle, no wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign op = pkf_pkg::pkf_op_t'(op_code);
	assign top_of_stack_field = fpsw_r[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB];
	assign st_phys = 3'(top_of_stack_field + op_reg);
	assign packed_op = (op == pkf_pkg::OP_PK_READ) || (op == pkf_pkg::OP_PK_WRITE) || (op == pkf_pkg::OP_PK_CLEAR);
	assign is_save = (op == pkf_pkg::OP_SAVE) || (op == pkf_pkg::OP_SAVE_EXT);
	assign is_restore = (op == pkf_pkg::OP_RESTORE) || (op == pkf_pkg::OP_RESTORE_EXT);

	// fault priority: invalid opcode, device unavailable, fp error, memory, alignment
	always_comb
	begin
		flt = pkf_pkg::FLT_NONE;
		if (packed_op && ctrl_r[pkf_pkg::CTRL_SOFT_FPU_BIT])
			flt = pkf_pkg::FLT_INVALID_OP;
		else if (packed_op && ctrl_r[pkf_pkg::CTRL_CTX_SW_BIT])
			flt = pkf_pkg::FLT_DEV_UNAVAIL;
		else if (packed_op && fp_exc_pending)
			flt = pkf_pkg::FLT_FP_ERROR;
		else if (packed_op && mem_fault != pkf_pkg::MEM_NONE)
			flt = pkf_pkg::FLT_MEM;
		else if (packed_op && misaligned && cpl3_ac && ctrl_r[pkf_pkg::CTRL_ALIGN_EN_BIT])
			flt = pkf_pkg::FLT_ALIGN;
	end
	assign fault_hit = (flt != pkf_pkg::FLT_NONE);

	// operation and register-write next state
	always_comb
	begin
		for (int i = 0; i < 8; i++)
			slot_nxt[i] = slot_r[i];
		tagw_nxt = tagw_r;
		fpsw_nxt = fpsw_r;
		fpcw_nxt = fpcw_r;
		stag_nxt = stag_r;
		ctrl_nxt = ctrl_r;
		sel_nxt = sel_r;
		fault_nxt = pkf_pkg::FLT_NONE;
		pk_rdata_nxt = pk_rdata_r;
		st_rdata_nxt = st_rdata_r;
		tags_out_nxt = tags_out_r;
		ext_nxt = 1'b0;
		done_nxt = 1'b0;
		// software writes; the pipeline op below wins on shared state
		if (apb_wr)
		begin
			case (paddr)
				pkf_pkg::ADDR_CTRL: ctrl_nxt = pwdata;
				pkf_pkg::ADDR_FPSW: fpsw_nxt = pwdata[15:0];
				pkf_pkg::ADDR_TAGW: tagw_nxt = pwdata[15:0];
				pkf_pkg::ADDR_FPCW: fpcw_nxt = pwdata[15:0];
				pkf_pkg::ADDR_SLOT_SEL: sel_nxt = pwdata[2:0];
				pkf_pkg::ADDR_SLOT_LO: slot_nxt[sel_r][31:0] = pwdata;
				pkf_pkg::ADDR_SLOT_MID: slot_nxt[sel_r][63:32] = pwdata;
				pkf_pkg::ADDR_SLOT_HI: slot_nxt[sel_r][79:64] = pwdata[15:0];
				default: ;
			endcase
		end
		if (op_valid)
		begin
			done_nxt = 1'b1;
			fault_nxt = flt;
			// faults commit nothing; fp state stays for the handler
			if (!fault_hit)
			begin
				case (op)
					pkf_pkg::OP_PK_READ:
					begin
						pk_rdata_nxt = slot_r[op_reg][63:0];
						tagw_nxt = {8{pkf_pkg::TAG_VALID}};
						fpsw_nxt[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB] = 3'h0;
					end
					pkf_pkg::OP_PK_WRITE:
					begin
						slot_nxt[op_reg] = {pkf_pkg::HI_ONES, op_wdata[63:0]};
						tagw_nxt = {8{pkf_pkg::TAG_VALID}};
						fpsw_nxt[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB] = 3'h0;
					end
					pkf_pkg::OP_PK_CLEAR:
					begin
						tagw_nxt = {8{pkf_pkg::TAG_EMPTY}};
						fpsw_nxt[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB] = 3'h0;
					end
					pkf_pkg::OP_FP_WRITE:
					begin
						slot_nxt[st_phys] = op_wdata;
						tagw_nxt[2*st_phys +: 2] = pkf_pkg::TAG_VALID;
						st_rdata_nxt = op_wdata;
					end
					pkf_pkg::OP_FP_FREE:
						tagw_nxt[2*st_phys +: 2] = pkf_pkg::TAG_EMPTY;
					pkf_pkg::OP_SAVE, pkf_pkg::OP_SAVE_EXT:
					begin
						for (int i = 0; i < 8; i++)
						begin
							if (tagw_r[2*i +: 2] == pkf_pkg::TAG_EMPTY)
								tags_out_nxt[2*i +: 2] = pkf_pkg::TAG_EMPTY;
							else
								tags_out_nxt[2*i +: 2] = tag_of(slot_r[i]);
						end
						stag_nxt = tags_out_nxt;
						tagw_nxt = {8{pkf_pkg::TAG_EMPTY}};
						ext_nxt = (op == pkf_pkg::OP_SAVE_EXT);
					end
					pkf_pkg::OP_RESTORE, pkf_pkg::OP_RESTORE_EXT:
					begin
						// slot data restored by the pipeline beforehand; image kept
						for (int i = 0; i < 8; i++)
						begin
							if (op_tags_in[2*i +: 2] == pkf_pkg::TAG_EMPTY)
								tagw_nxt[2*i +: 2] = pkf_pkg::TAG_EMPTY;
							else
								tagw_nxt[2*i +: 2] = tag_of(slot_r[i]);
						end
						ext_nxt = (op == pkf_pkg::OP_RESTORE_EXT);
					end
					default: ;
				endcase
				if (!packed_op && !is_save && !is_restore)
					st_rdata_nxt = slot_nxt[st_phys];
			end
		end
	end

	// apb read mux, data registered for the access phase
	always_comb
	begin
		rdata_nxt = prdata;
		if (apb_rd)
		begin
			case (paddr)
				pkf_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
				pkf_pkg::ADDR_FPSW: rdata_nxt = {16'h0000, fpsw_r};
				pkf_pkg::ADDR_TAGW: rdata_nxt = {16'h0000, tagw_r};
				pkf_pkg::ADDR_FAULT: rdata_nxt = {29'h0, fault_r};
				pkf_pkg::ADDR_SLOT_SEL: rdata_nxt = {29'h0, sel_r};
				pkf_pkg::ADDR_SLOT_LO: rdata_nxt = slot_r[sel_r][31:0];
				pkf_pkg::ADDR_SLOT_MID: rdata_nxt = slot_r[sel_r][63:32];
				pkf_pkg::ADDR_SLOT_HI: rdata_nxt = {16'h0000, slot_r[sel_r][79:64]};
				pkf_pkg::ADDR_FPCW: rdata_nxt = {16'h0000, fpcw_r};
				pkf_pkg::ADDR_SAVED_TAGW: rdata_nxt = {16'h0000, stag_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 8; i++)
				slot_r[i] <= 80'h0;
			tagw_r <= pkf_pkg::TAGW_RESET;
			fpsw_r <= pkf_pkg::FPSW_RESET;
			fpcw_r <= pkf_pkg::FPCW_RESET;
			stag_r <= pkf_pkg::TAGW_RESET;
			ctrl_r <= pkf_pkg::CTRL_RESET;
			sel_r <= 3'h0;
			fault_r <= 3'h0;
			pk_rdata_r <= 64'h0;
			st_rdata_r <= 80'h0;
			tags_out_r <= 16'h0000;
			ext_r <= 1'b0;
			done_r <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < 8; i++)
				slot_r[i] <= slot_nxt[i];
			tagw_r <= tagw_nxt;
			fpsw_r <= fpsw_nxt;
			fpcw_r <= fpcw_nxt;
			stag_r <= stag_nxt;
			ctrl_r <= ctrl_nxt;
			sel_r <= sel_nxt;
			fault_r <= op_valid ? fault_nxt : fault_r;
			pk_rdata_r <= pk_rdata_nxt;
			st_rdata_r <= st_rdata_nxt;
			tags_out_r <= tags_out_nxt;
			ext_r <= ext_nxt;
			done_r <= done_nxt;
			prdata <= rdata_nxt;
		end
	end

	assign pk_rdata = pk_rdata_r;
	assign st_rdata = st_rdata_r;
	assign tags_out = tags_out_r;
	assign save_ext_vec = ext_r;
	assign done = done_r;
	assign fault = fault_r;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence pk_issue;
		op_valid && clk_en && packed_op;
	endsequence

	// packed op that passes both trap flags
	sequence pk_run;
		pk_issue ##0 !ctrl_r[pkf_pkg::CTRL_SOFT_FPU_BIT] && !ctrl_r[pkf_pkg::CTRL_CTX_SW_BIT];
	endsequence

	// floating-point, save and restore ops never fault here
	sequence fp_issue;
		op_valid && clk_en && !packed_op;
	endsequence

	// fault gating ahead of any execution
	trap_invalid_a: assert property (pk_issue ##0 ctrl_r[pkf_pkg::CTRL_SOFT_FPU_BIT]
		|=> fault == pkf_pkg::FLT_INVALID_OP)
		else $error("soft trap did not give invalid opcode");
	ctx_unavail_a: assert property (pk_issue ##0 !ctrl_r[pkf_pkg::CTRL_SOFT_FPU_BIT]
		&& ctrl_r[pkf_pkg::CTRL_CTX_SW_BIT] |=> fault == pkf_pkg::FLT_DEV_UNAVAIL)
		else $error("context flag did not give device unavailable");
	fp_err_fault_a: assert property (pk_run ##0 fp_exc_pending |=> fault == pkf_pkg::FLT_FP_ERROR)
		else $error("pending fp error did not fault first");
	mem_fault_a: assert property (pk_run ##0 !fp_exc_pending && mem_fault != pkf_pkg::MEM_NONE
		|=> fault == pkf_pkg::FLT_MEM)
		else $error("memory fault not reported");
	align_gate_a: assert property (op_valid && clk_en && !ctrl_r[pkf_pkg::CTRL_ALIGN_EN_BIT]
		|=> fault != pkf_pkg::FLT_ALIGN)
		else $error("alignment fault while checking disabled");
	pk_no_numeric_a: assert property (pk_issue ##0 !fp_exc_pending |=> fault != pkf_pkg::FLT_FP_ERROR)
		else $error("packed op raised a numeric fault");
	// packed side effects on slots, tags and status
	pk_write_hi_a: assert property (pk_issue ##0 op == pkf_pkg::OP_PK_WRITE && !fault_hit
		|=> slot_r[$past(op_reg)] == {pkf_pkg::HI_ONES, $past(op_wdata[63:0])})
		else $error("packed write did not fill slot");
	pk_tags_valid_a: assert property (pk_issue ##0 op != pkf_pkg::OP_PK_CLEAR && !fault_hit
		|=> tagw_r == {8{pkf_pkg::TAG_VALID}} && fpsw_r[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB] == 3'h0)
		else $error("packed op did not mark tags valid");
	clear_empty_a: assert property (pk_issue ##0 op == pkf_pkg::OP_PK_CLEAR && !fault_hit
		|=> tagw_r == {8{pkf_pkg::TAG_EMPTY}} && fpsw_r[pkf_pkg::TOS_MSB:pkf_pkg::TOS_LSB] == 3'h0)
		else $error("clear did not empty tags");
	clear_data_keep_a: assert property (pk_issue ##0 op == pkf_pkg::OP_PK_CLEAR && !apb_wr
		|=> slot_r[$past(op_reg)] == $past(slot_r[op_reg]))
		else $error("clear changed slot data");
	pk_status_keep_a: assert property (pk_issue ##0 !apb_wr
		|=> fpsw_r[10:0] == $past(fpsw_r[10:0]) && fpsw_r[15:14] == $past(fpsw_r[15:14])
		&& fpcw_r == $past(fpcw_r))
		else $error("packed op touched other status");
	pk_read_keep_a: assert property (pk_issue ##0 op == pkf_pkg::OP_PK_READ && !apb_wr
		|=> slot_r[$past(op_reg)] == $past(slot_r[op_reg]))
		else $error("packed read changed slot data");
	// a faulting op must look as if it never issued
	fault_commit_a: assert property (pk_issue ##0 fault_hit && !apb_wr
		|=> tagw_r == $past(tagw_r) && fpsw_r == $past(fpsw_r) && slot_r[$past(op_reg)] == $past(slot_r[op_reg]))
		else $error("faulting op committed state");
	// floating-point and save/restore tag handling
	fp_write_alias_a: assert property (fp_issue ##0 op == pkf_pkg::OP_FP_WRITE
		|=> slot_r[$past(st_phys)] == $past(op_wdata) && tagw_r[2*$past(st_phys) +: 2] == pkf_pkg::TAG_VALID)
		else $error("fp write did not reach its slot");
	st_read_a: assert property (fp_issue ##0 op == pkf_pkg::OP_FP_WRITE |=> st_rdata == $past(op_wdata))
		else $error("stack read data missed the write");
	fp_free_tag_a: assert property (fp_issue ##0 op == pkf_pkg::OP_FP_FREE
		|=> tagw_r[2*$past(st_phys) +: 2] == pkf_pkg::TAG_EMPTY)
		else $error("fp free did not empty its tag");
	save_empty_a: assert property (fp_issue ##0 is_save
		|=> tagw_r == {8{pkf_pkg::TAG_EMPTY}} && stag_r == tags_out)
		else $error("save left live tags");
	restore_empty_a: assert property (fp_issue ##0 is_restore
		|=> (tagw_r & empty_mask($past(op_tags_in))) == empty_mask($past(op_tags_in)))
		else $error("restore lost an empty tag");
	ext_flag_a: assert property (fp_issue ##0 (op == pkf_pkg::OP_SAVE_EXT || op == pkf_pkg::OP_RESTORE_EXT)
		|=> save_ext_vec)
		else $error("extended op did not flag vector state");
	// a low enable freezes state, bus writes included
	hold_freeze_a: assert property (!clk_en |=> tagw_r == $past(tagw_r) && fpsw_r == $past(fpsw_r)
		&& fpcw_r == $past(fpcw_r) && ctrl_r == $past(ctrl_r))
		else $error("state moved with the enable low");
	done_pulse_a: assert property (clk_en |=> done == $past(op_valid))
		else $error("done did not follow the issue");
endmodule : pkf_alias

// file: verilog/pkf_pkg.sv
// package for the packed-integer / floating-point register aliasing block
package pkf_pkg;
	// apb register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FPSW = 8'h04;
	localparam logic [7:0] ADDR_TAGW = 8'h08;
	localparam logic [7:0] ADDR_FAULT = 8'h0C;
	localparam logic [7:0] ADDR_SLOT_SEL = 8'h10;
	localparam logic [7:0] ADDR_SLOT_LO = 8'h14;
	localparam logic [7:0] ADDR_SLOT_MID = 8'h18;
	localparam logic [7:0] ADDR_SLOT_HI = 8'h1C;
	localparam logic [7:0] ADDR_FPCW = 8'h20;
	localparam logic [7:0] ADDR_SAVED_TAGW = 8'h24;
	// control register bit positions
	localparam int CTRL_WAIT_MON_BIT = 1;
	localparam int CTRL_SOFT_FPU_BIT = 2;
	localparam int CTRL_CTX_SW_BIT = 3;
	localparam int CTRL_ALIGN_EN_BIT = 18;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
	// status word layout
	localparam int TOS_LSB = 11;
	localparam int TOS_MSB = 13;
	localparam logic [15:0] FPSW_RESET = 16'h0000;
	localparam logic [15:0] FPCW_RESET = 16'h037F;
	localparam logic [15:0] TAGW_RESET = 16'hFFFF;
	// two-bit tag encodings
	localparam logic [1:0] TAG_VALID = 2'h0;
	localparam logic [1:0] TAG_ZERO = 2'h1;
	localparam logic [1:0] TAG_SPECIAL = 2'h2;
	localparam logic [1:0] TAG_EMPTY = 2'h3;
	localparam logic [15:0] HI_ONES = 16'hFFFF;
	// operation codes from the pipeline
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PK_READ = 4'h1,
		OP_PK_WRITE = 4'h2,
		OP_PK_CLEAR = 4'h3,
		OP_FP_WRITE = 4'h4,
		OP_FP_FREE = 4'h5,
		OP_SAVE = 4'h6,
		OP_RESTORE = 4'h7,
		OP_SAVE_EXT = 4'h8,
		OP_RESTORE_EXT = 4'h9
	} pkf_op_t;
	// fault codes
	typedef enum logic [2:0] {
		FLT_NONE = 3'h0,
		FLT_INVALID_OP = 3'h1,
		FLT_DEV_UNAVAIL = 3'h2,
		FLT_FP_ERROR = 3'h3,
		FLT_MEM = 3'h4,
		FLT_ALIGN = 3'h5
	} pkf_fault_t;
	// memory fault sub-kinds
	localparam logic [1:0] MEM_NONE = 2'h0;
	localparam logic [1:0] MEM_STACK = 2'h1;
	localparam logic [1:0] MEM_PROT = 2'h2;
	localparam logic [1:0] MEM_PAGE = 2'h3;
endpackage : pkf_pkg

// file: test/pkf_pipe_model.sv
// pipeline model: issues queued operations to the aliasing block, one per cycle
module pkf_pipe_model
(
	input wire logic pclk, // core clock
	input wire logic presetn, // reset, active low
	output logic op_valid, // operation strobe
	output logic [3:0] op_code, // operation code
	output logic [2:0] op_reg, // register index
	output logic [79:0] op_wdata, // write data
	output logic [15:0] op_tags_in, // restore tag image
	output logic fp_exc_pending, // pending fp error
	output logic [1:0] mem_fault, // memory fault kind
	output logic misaligned, // misaligned operand
	output logic cpl3_ac // user alignment enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [107:0] pend_q[$];
	// queue a request; queued requests go out back to back
	task send(input logic [3:0] c, input logic [2:0] r, input logic [79:0] d, input logic [15:0] t, input logic [4:0] x);
		pend_q.push_back({c, r, d, t, x});
	endtask : send
	// idle cycles flip the data so a stale value never looks fresh
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{op_valid, op_code, op_reg, op_wdata, op_tags_in, fp_exc_pending, mem_fault, misaligned, cpl3_ac} <= '0;
		else if (pend_q.size() != 0)
			{op_valid, op_code, op_reg, op_wdata, op_tags_in, fp_exc_pending, mem_fault, misaligned, cpl3_ac} <= {1'b1, pend_q.pop_front()};
		else
			{op_valid, op_wdata} <= {1'b0, ~op_wdata};
	end
endmodule : pkf_pipe_model

// file: test/pkf_alias_tb.sv
// self-checking bench for the packed/fp register aliasing block
module pkf_alias_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, op_valid, fp_exc_pending, misaligned, cpl3_ac, save_ext_vec, done;
	logic [3:0] op_code;
	logic [2:0] op_reg, fault;
	logic [79:0] op_wdata, st_rdata;
	logic [15:0] op_tags_in, tags_out;
	logic [1:0] mem_fault;
	logic [63:0] pk_rdata, d0, d3;
	logic [68:0] exp_q[$];
	logic [68:0] e;
	int mismatches = 0;
	int num_checks = 0;
	always #2 pclk = ~pclk;
	pkf_alias i_pkf_alias (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_valid(op_valid), .op_code(op_code), .op_reg(op_reg), .op_wdata(op_wdata), .op_tags_in(op_tags_in),
		.fp_exc_pending(fp_exc_pending), .mem_fault(mem_fault), .misaligned(misaligned), .cpl3_ac(cpl3_ac),
		.pk_rdata(pk_rdata), .st_rdata(st_rdata), .tags_out(tags_out), .save_ext_vec(save_ext_vec), .done(done),
		.fault(fault));
	pkf_pipe_model i_pkf_pipe_model (.pclk(pclk), .presetn(presetn), .op_valid(op_valid), .op_code(op_code),
		.op_reg(op_reg), .op_wdata(op_wdata), .op_tags_in(op_tags_in), .fp_exc_pending(fp_exc_pending),
		.mem_fault(mem_fault), .misaligned(misaligned), .cpl3_ac(cpl3_ac));
	// compare one value and count it
	task check(input logic [79:0] seen, input logic [79:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task conclude;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// one apb transfer; only the watchdog ends a wait for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(80'(rd), 80'(exp));
	endtask : rchk
	// queue an operation and its expected result; sel 1 data, 2 tag image, 3 vector flag
	task op(input logic [3:0] c, input logic [2:0] r, input logic [79:0] d, input logic [15:0] t, input logic [4:0] x,
		input logic [1:0] s, input logic [2:0] f, input logic [63:0] v);
		i_pkf_pipe_model.send(c, r, d, t, x);
		exp_q.push_back({s, f, v});
	endtask : op
	task drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100)
		begin
			mismatches++;
			conclude();
		end
	endtask : drain
	// result monitor: every done takes the oldest note
	always @(posedge pclk)
		if (done === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(80'h1, 80'h0);
			else
			begin
				e = exp_q.pop_front();
				check(80'(fault), 80'(e[66:64]));
				case (e[68:67])
					2'h1: check(80'(pk_rdata), 80'(e[63:0]));
					2'h2: check(80'(tags_out), 80'(e[15:0]));
					2'h3: check(80'(save_ext_vec), 80'(e[0]));
					default: ;
				endcase
			end
		end
	// watchdog: 20000 cycles, the whole run needs under two hundred
	initial
	begin
		#80000;
		mismatches++;
		conclude();
	end
	initial
	begin
		void'($urandom(33));
		d0 = {$urandom, $urandom};
		d3 = {$urandom, $urandom};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFFF);
		rchk(pkf_pkg::ADDR_FPCW, 32'h0000_037F);
		rchk(pkf_pkg::ADDR_CTRL, 32'h0000_0002);
		rchk(pkf_pkg::ADDR_FPSW, 32'h0);
		apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		rchk(8'h3C, 32'h0);
		// a bus write with the enable low must not land
		clk_en <= 1'b0;
		apb(1'b1, pkf_pkg::ADDR_FPCW, 32'h0000_1234);
		clk_en <= 1'b1;
		rchk(pkf_pkg::ADDR_FPCW, 32'h0000_037F);
		$display("test reset done");
		// fault gating; a pending fp error must lose to both flag faults
		apb(1'b1, pkf_pkg::ADDR_FPSW, 32'h0000_D7FF);
		for (int i = 1; i < 4; i++)
		begin
			apb(1'b1, pkf_pkg::ADDR_CTRL, 32'h2 | (32'(i) << 2));
			op(pkf_pkg::OP_PK_WRITE, 3'h5, 80'(d3), 16'h0, 5'h10, 2'h0,
				i[0] ? pkf_pkg::FLT_INVALID_OP : pkf_pkg::FLT_DEV_UNAVAIL, 64'h0);
			drain();
		end
		apb(1'b1, pkf_pkg::ADDR_CTRL, 32'h0004_0002);
		op(pkf_pkg::OP_PK_WRITE, 3'h5, 80'(d3), 16'h0, 5'h10, 2'h0, pkf_pkg::FLT_FP_ERROR, 64'h0);
		for (int m = 1; m < 4; m++)
			op(pkf_pkg::OP_PK_WRITE, 3'h5, 80'(d3), 16'h0, {1'b0, 2'(m), 2'h3}, 2'h0, pkf_pkg::FLT_MEM, 64'h0);
		op(pkf_pkg::OP_PK_CLEAR, 3'h5, 80'h0, 16'h0, 5'h03, 2'h0, pkf_pkg::FLT_ALIGN, 64'h0);
		drain();
		rchk(pkf_pkg::ADDR_FPSW, 32'h0000_D7FF);
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFFF);
		apb(1'b1, pkf_pkg::ADDR_CTRL, 32'h0000_0002);
		op(pkf_pkg::OP_PK_READ, 3'h5, 80'h0, 16'h0, 5'h03, 2'h1, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		$display("test faults done");
		// stack-relative write with top of stack 2 lands in physical slot 0
		apb(1'b1, pkf_pkg::ADDR_FPSW, 32'h0000_D7FF);
		op(pkf_pkg::OP_FP_WRITE, 3'h6, {16'h3FFF, 1'b1, d0[62:0]}, 16'h0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		op(pkf_pkg::OP_PK_READ, 3'h0, 80'h0, 16'h0, 5'h0, 2'h1, pkf_pkg::FLT_NONE, {1'b1, d0[62:0]});
		op(pkf_pkg::OP_PK_WRITE, 3'h3, {16'h1234, d3}, 16'h0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		check(st_rdata, {16'h3FFF, 1'b1, d0[62:0]});
		rchk(pkf_pkg::ADDR_FPSW, 32'h0000_C7FF);
		rchk(pkf_pkg::ADDR_TAGW, 32'h0);
		apb(1'b1, pkf_pkg::ADDR_SLOT_SEL, 32'h3);
		rchk(pkf_pkg::ADDR_SLOT_LO, d3[31:0]);
		rchk(pkf_pkg::ADDR_SLOT_MID, d3[63:32]);
		rchk(pkf_pkg::ADDR_SLOT_HI, 32'h0000_FFFF);
		$display("test alias done");
		// clear keeps data; save classifies slots 0 valid, 3 special, rest zero
		op(pkf_pkg::OP_PK_CLEAR, 3'h0, 80'h0, 16'h0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFFF);
		op(pkf_pkg::OP_PK_READ, 3'h3, 80'h0, 16'h0, 5'h0, 2'h1, pkf_pkg::FLT_NONE, d3);
		op(pkf_pkg::OP_SAVE, 3'h0, 80'h0, 16'h0, 5'h0, 2'h2, pkf_pkg::FLT_NONE, 64'h5594);
		drain();
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFFF);
		rchk(pkf_pkg::ADDR_SAVED_TAGW, 32'h0000_5594);
		op(pkf_pkg::OP_SAVE_EXT, 3'h0, 80'h0, 16'h0, 5'h0, 2'h3, pkf_pkg::FLT_NONE, 64'h1);
		op(pkf_pkg::OP_RESTORE, 3'h0, 80'h0, 16'hFFF0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFF4);
		op(pkf_pkg::OP_RESTORE_EXT, 3'h0, 80'h0, 16'hFFFF, 5'h0, 2'h3, pkf_pkg::FLT_NONE, 64'h1);
		op(pkf_pkg::OP_FP_WRITE, 3'h2, 80'(d0), 16'h0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFCF);
		op(pkf_pkg::OP_FP_FREE, 3'h2, 80'h0, 16'h0, 5'h0, 2'h0, pkf_pkg::FLT_NONE, 64'h0);
		drain();
		rchk(pkf_pkg::ADDR_TAGW, 32'h0000_FFFF);
		$display("test save restore done");
		conclude();
	end
endmodule : pkf_alias_tb
